// ---- diphase_tape_codec.sv ----
// Top of the diphase tape codec: mode control, two record encoders and two playback decoders.
`timescale 1ns/1ps
`default_nettype none
module diphase_tape_codec
  import diphase_pkg::*;
#(
  parameter int CELL_CYC = PB_CELL_CYC
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // Mode commands, levels from outside
  input wire logic REC_CMD,
  input wire logic PLAY_CMD,
  input wire logic STOP_CMD,
  input wire logic TAPE_START,
  // Record inputs: return-to-zero data per track and the shared record clock
  input wire logic [TRACKS-1:0] RZ_DATA,
  input wire logic REC_CLK,
  // Playback inputs: limited signal and complement per track
  input wire logic [TRACKS-1:0] PB_SIG,
  input wire logic [TRACKS-1:0] PB_SIG_N,
  // Record head streams
  output logic [TRACKS-1:0] DIPHASE_OUT,
  // Transport and head controls
  output logic ERASE_EN,
  output logic TAPE_REVERSE,
  output logic TAPE_FAST,
  output logic RECORDING,
  // Decoded playback data
  output logic [TRACKS-1:0] NRZ_DATA,
  output logic [TRACKS-1:0] NRZ_STROBE
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Every pin but MCLK and RST_B passes two flops; only the second stage is read by logic.
  logic [2:0] cmd_meta;
  logic [2:0] cmd_sync;
  logic start_meta;
  logic start_sync;
  logic clk_meta;
  logic clk_sync;
  logic [TRACKS-1:0] rz_meta;
  logic [TRACKS-1:0] rz_sync;
  logic [TRACKS-1:0] pb_meta;
  logic [TRACKS-1:0] pb_sync;
  logic [TRACKS-1:0] pbn_meta;
  logic [TRACKS-1:0] pbn_sync;

  // Two-flop synchronisers for all pins but MCLK and RST_B.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      cmd_meta <= '0;
      cmd_sync <= '0;
      start_meta <= 1'b0;
      start_sync <= 1'b0;
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      rz_meta <= '0;
      rz_sync <= '0;
      pb_meta <= '0;
      pb_sync <= '0;
      pbn_meta <= '0;
      pbn_sync <= '0;
    end else begin
      cmd_meta <= {STOP_CMD, PLAY_CMD, REC_CMD};
      cmd_sync <= cmd_meta;
      start_meta <= TAPE_START;
      start_sync <= start_meta;
      clk_meta <= REC_CLK;
      clk_sync <= clk_meta;
      rz_meta <= RZ_DATA;
      rz_sync <= rz_meta;
      pb_meta <= PB_SIG;
      pb_sync <= pb_meta;
      pbn_meta <= PB_SIG_N;
      pbn_sync <= pbn_meta;
    end
  end

  // ****************************************************************
  // Mode control
  // ****************************************************************
  mode_t mode;
  mode_t next_mode;
  logic [2:0] cmd_prev;
  logic [2:0] cmd_rise;
  tape_ctl_t ctl;
  tape_ctl_t next_ctl;

  // Commands act on their rising edge so a held level fires once.
  assign cmd_rise = cmd_sync & ~cmd_prev;

  // Stop outranks playback, which outranks record.
  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_STOP: begin
        if (cmd_rise[1]) begin
          next_mode = MODE_PLAYBACK;
        end else if (cmd_rise[0]) begin
          next_mode = MODE_RECORD;
        end
      end
      MODE_RECORD: begin
        if (cmd_rise[2]) begin
          next_mode = MODE_STOP;
        end else if (cmd_rise[1]) begin
          // [RULE7] playback ends recording
          next_mode = MODE_PLAYBACK;
        end
      end
      MODE_PLAYBACK: begin
        // Rewinding ends when the tape is back at its start.
        if (cmd_rise[2] || start_sync) begin
          next_mode = MODE_STOP;
        end
      end
      default: begin
        next_mode = MODE_STOP;
      end
    endcase
  end

  // Controls follow the next mode so they change in the same cycle as the mode.
  always_comb begin
    next_ctl = CTL_IDLE;
    case (next_mode)
      MODE_RECORD: begin
        // [RULE6] erase only when recording
        next_ctl.erase = 1'b1;
        next_ctl.record = 1'b1;
      end
      MODE_PLAYBACK: begin
        // [RULE7] reverse at high speed
        next_ctl.reverse = 1'b1;
        next_ctl.fast = 1'b1;
      end
      default: begin
        next_ctl = CTL_IDLE;
      end
    endcase
  end

  // Mode and control registers.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      mode <= MODE_STOP;
      cmd_prev <= '0;
      ctl <= CTL_IDLE;
    end else begin
      mode <= next_mode;
      cmd_prev <= cmd_sync;
      ctl <= next_ctl;
    end
  end

  assign ERASE_EN = ctl.erase;
  assign TAPE_REVERSE = ctl.reverse;
  assign TAPE_FAST = ctl.fast;
  assign RECORDING = ctl.record;

  // ****************************************************************
  // Record encoders
  // ****************************************************************
  // The clock edges are found once and shared by both tracks.
  logic clk_prev;
  logic clk_rise;
  logic [TRACKS-1:0] bit_hold;
  logic [TRACKS-1:0] next_bit_hold;
  logic [TRACKS-1:0] comb_prev;
  logic [TRACKS-1:0] comb_now;
  logic [TRACKS-1:0] diphase;
  logic [TRACKS-1:0] next_diphase;

  assign clk_rise = clk_sync && !clk_prev;

  // The source holds data high with the clock high for a one.
  // [RULE11] clock high with one pulse
  always_comb begin
    next_bit_hold = bit_hold;
    if (clk_sync) begin
      next_bit_hold = bit_hold | rz_sync;
    end
    if (clk_rise) begin
      next_bit_hold = rz_sync;
    end
  end

  // The return-to-zero pulse falls with the clock, so the bit is held for the whole cell;
  // otherwise the OR would never see a falling edge at mid-cell.
  // [RULE1] inverted data OR clock
  assign comb_now = ~bit_hold | {TRACKS{clk_sync}};

  // One toggle flop per track; separate state keeps the tracks independent.
  always_comb begin
    next_diphase = diphase;
    for (int t = 0; t < TRACKS; t++) begin
      if (!ctl.record) begin
        next_diphase[t] = 1'b0;
      end else if (clk_rise) begin
        // [RULE2] boundary transition every cell
        next_diphase[t] = ~diphase[t];
      end else if (comb_prev[t] && !comb_now[t]) begin
        // [RULE3] mid-cell transition for a one
        next_diphase[t] = ~diphase[t];
      end
    end
  end

  // [RULE5] two encoder paths
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      clk_prev <= 1'b0;
      bit_hold <= '0;
      comb_prev <= '1;
      diphase <= '0;
    end else begin
      clk_prev <= clk_sync;
      bit_hold <= next_bit_hold;
      comb_prev <= comb_now;
      diphase <= next_diphase;
    end
  end

  assign DIPHASE_OUT = diphase;

  // ****************************************************************
  // Playback decoders
  // ****************************************************************
  nrz_t nrz [TRACKS];

  // Each track gets its own extractor and decoder, enabled only in playback.
  for (genvar g = 0; g < TRACKS; g++) begin : g_dec
    diphase_decoder #(
      .CELL_CYC(CELL_CYC)
    ) u_dec (
      .clk(MCLK),
      .rst_b(RST_B),
      .enable(ctl.fast),
      .sig(pb_sync[g]),
      .sig_n(pbn_sync[g]),
      .nrz(nrz[g])
    );
    assign NRZ_DATA[g] = nrz[g].data;
    assign NRZ_STROBE[g] = nrz[g].strobe;
  end

endmodule
`default_nettype wire

// ---- diphase_pkg.sv ----
// Shared constants and types for the diphase tape record encoder and playback decoder.
// Behaviour
// [RULE1] The encoder ORs the inverted held data with the record clock and toggles one flip-flop on each falling edge of that combination, and that flip-flop is the record stream.
// [RULE2] A zero bit is recorded as a square wave at half the bit rate, changing level only at the cell boundary.
// [RULE3] A one bit adds a transition at mid-cell, so the stream runs at the full bit rate for that cell.
// [RULE4] The source delivers return-to-zero data with its clock at 5120 bits per second.
// [RULE5] Two tracks are encoded and recorded together, each through its own encoder.
// [RULE6] Erase is on only in record mode and never in playback or stop.
// [RULE7] A playback command stops recording, reverses the tape and runs it at 22 times record speed while the data is decoded.
// [RULE8] In playback the limited signal and its complement both go to the timing extractor and the data decoder.
// [RULE9] Bit timing comes from transitions of the played-back signal through one-shot timing, not from an outside clock.
// [RULE10] Each bit is decided from the recovered timing and the signal and is given out as NRZ data.
// [RULE11] The source clock has a 50 percent duty cycle and is high while a one pulse is present.
// [RULE12] A bit is a one when a transition falls inside the mid-cell window and a zero when none does.
package diphase_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 50000000;
  localparam int REC_BIT_RATE = 5120;
  localparam int PB_SPEED_RATIO = 22;
  localparam int PB_BIT_RATE = REC_BIT_RATE * PB_SPEED_RATIO;
  // Played-back cell length in system clock cycles.
  localparam int PB_CELL_CYC = CLK_HZ / PB_BIT_RATE;
  localparam int CNT_W = 11;
  localparam int TRACKS = 2;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Transport mode, Gray coded along stop, record, playback.
  typedef enum logic [1:0] {
    MODE_STOP = 2'h0,
    MODE_RECORD = 2'h1,
    MODE_PLAYBACK = 2'h3
  } mode_t;

  // One decoded NRZ bit with its one-cycle strobe.
  typedef struct packed {
    logic data;
    logic strobe;
  } nrz_t;

  // Transport and head controls.
  typedef struct packed {
    logic erase;
    logic reverse;
    logic fast;
    logic record;
  } tape_ctl_t;

  localparam tape_ctl_t CTL_IDLE = 4'h0;

endpackage

// ---- diphase_decoder.sv ----
// Playback timing extractor and data decoder for one diphase track.
`timescale 1ns/1ps
`default_nettype none
module diphase_decoder
  import diphase_pkg::*;
#(
  parameter int CELL_CYC = PB_CELL_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic enable,
  // Synchronised limited signal and its complement
  input wire logic sig,
  input wire logic sig_n,
  // Decoded output
  output var nrz_t nrz
);

  localparam logic [CNT_W-1:0] WIN_OPEN = CNT_W'(CELL_CYC / 4);
  localparam logic [CNT_W-1:0] WIN_CLOSE = CNT_W'((3 * CELL_CYC) / 4);
  localparam logic [CNT_W-1:0] LOST_CYC = CNT_W'(2 * CELL_CYC);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic sig_prev;
  logic next_sig_prev;
  logic locked;
  logic next_locked;
  logic mid_seen;
  logic next_mid_seen;
  nrz_t next_nrz;
  logic edge_seen;

  // A level counts only while the two rails disagree, and only such a level is remembered.
  // A spike on one rail therefore cannot fake a transition on its way back either.
  // [RULE8] both rails used
  assign edge_seen = (sig != sig_prev) && (sig != sig_n);
  assign next_sig_prev = (sig != sig_n) ? sig : sig_prev;

  // One-shot timing: the counter restarts on each boundary transition and times the cell.
  always_comb begin
    next_cnt = cnt;
    next_locked = locked;
    next_mid_seen = mid_seen;
    next_nrz.data = nrz.data;
    next_nrz.strobe = 1'b0;
    if (!enable) begin
      next_cnt = '0;
      next_locked = 1'b0;
      next_mid_seen = 1'b0;
    end else begin
      if (cnt != LOST_CYC) begin
        next_cnt = cnt + CNT_W'(1);
      end
      if (edge_seen) begin
        // [RULE9] one-shot boundary timing
        if (!locked || cnt >= WIN_CLOSE) begin
          if (locked) begin
            // [RULE10] NRZ bit out
            next_nrz.data = mid_seen;
            next_nrz.strobe = 1'b1;
          end
          next_locked = 1'b1;
          next_cnt = '0;
          next_mid_seen = 1'b0;
        end else if (cnt >= WIN_OPEN) begin
          // [RULE12] mid-cell window
          next_mid_seen = 1'b1;
        end
      end else if (cnt == LOST_CYC) begin
        // Two silent cells mean dropout; relock on the next transition.
        next_locked = 1'b0;
      end
    end
  end

  // Registers for the extractor and decoder.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt <= '0;
      sig_prev <= 1'b0;
      locked <= 1'b0;
      mid_seen <= 1'b0;
      nrz <= '0;
    end else begin
      cnt <= next_cnt;
      sig_prev <= next_sig_prev;
      locked <= next_locked;
      mid_seen <= next_mid_seen;
      nrz <= next_nrz;
    end
  end

endmodule
`default_nettype wire

// ---- diphase_tape_codec_checker.sv ----
// Port assertions for the diphase tape codec.
`timescale 1ns/1ps
`default_nettype none
module diphase_tape_codec_checker
  import diphase_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // Commands
  input wire logic REC_CMD,
  input wire logic PLAY_CMD,
  input wire logic STOP_CMD,
  // Outputs watched
  input wire logic [TRACKS-1:0] DIPHASE_OUT,
  input wire logic ERASE_EN,
  input wire logic TAPE_REVERSE,
  input wire logic TAPE_FAST,
  input wire logic RECORDING,
  input wire logic [TRACKS-1:0] NRZ_DATA,
  input wire logic [TRACKS-1:0] NRZ_STROBE
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  erase_in_rec_a: assert property (ERASE_EN |-> RECORDING && !TAPE_REVERSE)
    else $error("erase outside record");
  rec_start_a: assert property ($rose(REC_CMD) && !RECORDING && !TAPE_REVERSE && !PLAY_CMD
    && !STOP_CMD |-> ##[1:4] (RECORDING && ERASE_EN)) else $error("record not entered");
  play_mode_a: assert property (TAPE_FAST |-> TAPE_REVERSE && !RECORDING)
    else $error("fast without reverse");
  play_start_a: assert property ($rose(PLAY_CMD) && !TAPE_REVERSE && !STOP_CMD
    |-> ##[1:4] (TAPE_FAST && TAPE_REVERSE)) else $error("playback not entered");
  rec_idle_a: assert property (!RECORDING && !$past(RECORDING) |-> DIPHASE_OUT == '0)
    else $error("record stream active outside record");
  strobe_pulse_a: assert property (NRZ_STROBE[0] |=> !NRZ_STROBE[0])
    else $error("strobe longer than one cycle");
  nrz_hold_a: assert property (NRZ_STROBE == '0 && TAPE_REVERSE && $past(TAPE_REVERSE)
    |-> $stable(NRZ_DATA)) else $error("data moved without strobe");
  strobe_play_a: assert property (|NRZ_STROBE |-> TAPE_REVERSE || $past(TAPE_REVERSE))
    else $error("strobe outside playback");
  cover property ($rose(ERASE_EN));
  cover property (NRZ_STROBE[0] && NRZ_DATA[0]);
  cover property ($rose(DIPHASE_OUT[1]));
endmodule
bind diphase_tape_codec diphase_tape_codec_checker chk (.MCLK(MCLK), .RST_B(RST_B),
  .REC_CMD(REC_CMD), .PLAY_CMD(PLAY_CMD), .STOP_CMD(STOP_CMD), .DIPHASE_OUT(DIPHASE_OUT),
  .ERASE_EN(ERASE_EN), .TAPE_REVERSE(TAPE_REVERSE), .TAPE_FAST(TAPE_FAST),
  .RECORDING(RECORDING), .NRZ_DATA(NRZ_DATA), .NRZ_STROBE(NRZ_STROBE));
`default_nettype wire

// ---- diphase_far_end.sv ----
// Behavioural far end: record source and tape playback rails for both tracks.
`timescale 1ns/1ps
`default_nettype none
module diphase_far_end
  import diphase_pkg::*;
#(
  parameter int HALF_NS = 80,
  parameter int PB_HALF_NS = 400
) (
  // Record source
  output logic rec_clk,
  output logic [TRACKS-1:0] rz_data,
  // Playback rails
  output logic [TRACKS-1:0] pb_sig,
  output logic [TRACKS-1:0] pb_sig_n
);
  // Clock stands low outside frames.
  initial begin
    rec_clk = 1'b0;
    rz_data = '0;
    pb_sig = '0;
    pb_sig_n = '1;
  end
  task automatic send_rec(input logic [7:0] d0, input logic [7:0] d1);
    for (int i = 0; i < 8; i++) begin
      rec_clk = 1'b1;
      rz_data = {d1[i], d0[i]};
      #(HALF_NS);
      rec_clk = 1'b0;
      rz_data = '0;
      #(HALF_NS);
    end
  endtask
  // one-rail spike
  // A short pulse on one rail only, with the other rail left alone; the decoder must not see it.
  task automatic spike(input int t);
    pb_sig[t] = 1'b1;
    #(PB_HALF_NS / 4);
    pb_sig[t] = 1'b0;
    #(PB_HALF_NS / 2);
  endtask
  // both rails driven
  // Edge at each boundary, extra mid edge for ones; a closing boundary flushes the last bit.
  task automatic play(input logic [7:0] d0, input logic [7:0] d1);
    for (int i = 0; i < 9; i++) begin
      pb_sig = ~pb_sig;
      pb_sig_n = ~pb_sig;
      #(PB_HALF_NS);
      if (i < 8) begin
        pb_sig = pb_sig ^ {d1[i], d0[i]};
      end
      pb_sig_n = ~pb_sig;
      #(PB_HALF_NS);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb_diphase_tape_codec.sv ----
// Self-checking bench for the diphase tape codec.
`timescale 1ns/1ps
`default_nettype none
module tb_diphase_tape_codec
  import diphase_pkg::*;
;
  // Short played-back cell keeps the run brief.
  localparam int CELL = 40;
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  logic REC_CMD = 1'b0;
  logic PLAY_CMD = 1'b0;
  logic STOP_CMD = 1'b0;
  logic TAPE_START = 1'b0;
  logic REC_CLK;
  logic [TRACKS-1:0] RZ_DATA, PB_SIG, PB_SIG_N, DIPHASE_OUT, NRZ_DATA, NRZ_STROBE;
  logic ERASE_EN, TAPE_REVERSE, TAPE_FAST, RECORDING;
  logic [TRACKS-1:0] last_out = '0;
  logic [7:0] rx0, rx1;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int nstb = 0;
  int tog [TRACKS];
  always #10 MCLK = ~MCLK;
  diphase_tape_codec #(.CELL_CYC(CELL)) dut (.MCLK(MCLK), .RST_B(RST_B), .REC_CMD(REC_CMD),
    .PLAY_CMD(PLAY_CMD), .STOP_CMD(STOP_CMD), .TAPE_START(TAPE_START), .RZ_DATA(RZ_DATA),
    .REC_CLK(REC_CLK), .PB_SIG(PB_SIG), .PB_SIG_N(PB_SIG_N), .DIPHASE_OUT(DIPHASE_OUT),
    .ERASE_EN(ERASE_EN), .TAPE_REVERSE(TAPE_REVERSE), .TAPE_FAST(TAPE_FAST),
    .RECORDING(RECORDING), .NRZ_DATA(NRZ_DATA), .NRZ_STROBE(NRZ_STROBE));
  diphase_far_end #(.HALF_NS(80), .PB_HALF_NS(CELL * 10)) far (.rec_clk(REC_CLK),
    .rz_data(RZ_DATA), .pb_sig(PB_SIG), .pb_sig_n(PB_SIG_N));
  // ****
  // Monitors
  // ****
  // Edge counts and decoded bits, read before the edge's updates land.
  always @(posedge MCLK) begin
    for (int t = 0; t < TRACKS; t++) begin
      tog[t] += int'(DIPHASE_OUT[t] != last_out[t]);
    end
    last_out = DIPHASE_OUT;
    if (NRZ_STROBE[0]) rx0 = {NRZ_DATA[0], rx0[7:1]};
    if (NRZ_STROBE[1]) rx1 = {NRZ_DATA[1], rx1[7:1]};
    nstb += int'(NRZ_STROBE[0]) + int'(NRZ_STROBE[1]);
  end
  // Hang guard, well above the expected run.
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  // ****
  // Tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A command is a short level pulse, then time for the three-edge answer.
  task automatic pulse(ref logic pin);
    @(posedge MCLK);
    #1;
    pin = 1'b1;
    repeat (2) @(posedge MCLK);
    #1;
    pin = 1'b0;
    repeat (6) @(posedge MCLK);
    #1;
  endtask
  task automatic scn_modes();
    pulse(REC_CMD);
    check({ERASE_EN, RECORDING, TAPE_FAST}, 3'h6);
    pulse(PLAY_CMD);
    check({ERASE_EN, RECORDING, TAPE_REVERSE, TAPE_FAST}, 4'h3);
    pulse(REC_CMD);
    check({ERASE_EN, RECORDING, TAPE_REVERSE}, 3'h1);
    TAPE_START = 1'b1;
    repeat (8) @(posedge MCLK);
    #1;
    TAPE_START = 1'b0;
    check({ERASE_EN, TAPE_REVERSE, TAPE_FAST}, 3'h0);
    pulse(REC_CMD);
    pulse(STOP_CMD);
    check({ERASE_EN, RECORDING}, 2'h0);
  endtask
  task automatic scn_record(input logic [7:0] d);
    pulse(REC_CMD);
    tog[0] = 0;
    tog[1] = 0;
    far.send_rec(d, ~d);
    repeat (8) @(posedge MCLK);
    #1;
    check(16'(tog[0]), 16'(8 + $countones(d)));
    check(16'(tog[1]), 16'(8 + $countones(~d)));
    pulse(STOP_CMD);
  endtask
  task automatic scn_play();
    pulse(PLAY_CMD);
    nstb = 0;
    // Spikes on one rail ahead of the frame must neither lock the decoder nor add a bit.
    far.spike(0);
    far.spike(1);
    far.play(8'hb4, 8'h6c);
    repeat (4) @(posedge MCLK);
    #1;
    check(16'(nstb), 16'h10);
    check(rx0, 8'hb4);
    check(rx1, 8'h6c);
    pulse(STOP_CMD);
    check({TAPE_REVERSE, TAPE_FAST}, 2'h0);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    tog[0] = 0;
    tog[1] = 0;
    repeat (10) @(posedge MCLK);
    #1;
    RST_B = 1'b1;
    scn_modes();
    scn_record(8'h00);
    scn_record(8'hff);
    scn_record(8'h4b);
    scn_play();
    final_report();
  end
endmodule
`default_nettype wire
